//--- pscp_pkg.sv
package pscp_pkg;

  // register byte addresses on the bus, one aligned word each
  localparam logic [7:0] PSCP_DATA_PORT_ADR = 8'h00;
  localparam logic [7:0] PSCP_DATA_LATCH_ADR = 8'h04;
  localparam logic [7:0] PSCP_DATA_DIR_ADR = 8'h08;
  localparam logic [7:0] PSCP_CTL_LEVEL_ADR = 8'h0c;
  localparam logic [7:0] PSCP_CTL_LATCH_ADR = 8'h10;
  localparam logic [7:0] PSCP_CTL_STATUS_ADR = 8'h14;
  localparam logic [7:0] PSCP_FLAG_ADR = 8'h18;
  localparam logic [7:0] PSCP_ENABLE_ADR = 8'h1c;
  localparam logic [7:0] PSCP_PRIORITY_ADR = 8'h20;
  localparam logic [7:0] PSCP_ANALOG_ADR = 8'h24;

  // control_direction_and_port_status field positions
  localparam int PSCP_IBF_BIT = 7;
  localparam int PSCP_OBF_BIT = 6;
  localparam int PSCP_INPUT_OVERFLOW_BIT = 5;
  localparam int PSCP_MODE_BIT = 4;
  // port_irq flag, enable and priority sit in bit 7 of their registers
  localparam int PSCP_IRQ_BIT = 7;

  // control pin indices in port mode
  localparam int PSCP_RD_PIN = 0;
  localparam int PSCP_WR_PIN = 1;
  localparam int PSCP_CS_PIN = 2;

  // reset values
  localparam logic [7:0] PSCP_DATA_DIR_RST = 8'hff;
  localparam logic [2:0] PSCP_CTL_DIR_RST = 3'h7;
  localparam logic [7:0] PSCP_ZERO8 = 8'h00;
  localparam logic [2:0] PSCP_ZERO3 = 3'h0;
  localparam logic [23:0] PSCP_PAD24 = 24'h000000;
  // analog_config_field codes with bits 2 and 1 both set make the control pins digital
  localparam logic [1:0] PSCP_DIGITAL_CODE = 2'h3;

  typedef enum {PSCP_IDLE, PSCP_EXT_WRITE, PSCP_EXT_READ} pscp_phase_e;

  // all state of the top module
  typedef struct packed {
    logic ack;
    logic [7:0] rdata;
    logic [7:0] data_latch;
    logic [7:0] data_dir;
    logic [7:0] in_latch;
    logic [7:0] data_sample;
    logic [2:0] ctl_latch;
    logic [2:0] ctl_dir;
    logic mode;
    logic input_buffer_full;
    logic output_buffer_full;
    logic input_overflow;
    logic irq_flag;
    logic irq_enable;
    logic irq_priority;
    logic [7:0] analog_cfg;
    pscp_phase_e phase;
  } pscp_state_s;

  // pin group carrier: data pins and control pins
  typedef struct packed {
    logic [7:0] data;
    logic [2:0] ctl;
  } pscp_pins_s;

endpackage

//--- pscp_sync.sv
`timescale 1ns/1ps
`default_nettype none
// two-stage synchroniser for pin levels
module pscp_sync #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // asynchronous level in, synchronised level out
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } pscp_sync_s;

  pscp_sync_s state_reg;
  pscp_sync_s state_next;

  // first stage feeds only the second stage
  always_comb begin
    state_next = state_reg;
    state_next.meta = async_i;
    state_next.stable = state_reg.meta;
  end

  // pins are high-ish idle, but reset to zero for a defined value
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign sync_o = state_reg.stable;

endmodule
`default_nettype wire

//--- pscp_top.sv
// Summary of operation
// RQ1: three control pins, each with its own direction bit.
// RQ2: direction one floats the pin; zero drives it from the output latch.
// RQ3: control latch register reads back the latch, never the pin levels.
// RQ4: control pins in analog use read as zero in the level register.
// RQ5: direction bits drive control pins even while they are analog.
// RQ6: after reset the control pins come up as analog inputs.
// RQ7: bit 7 shows a byte from the external master awaits the CPU.
// RQ8: bit 6 shows a CPU byte not yet read by the external master.
// RQ9: bit 5 sets on external write over an unread byte; software clears.
// RQ10: bit 4 selects port mode when one; bit 3 reads zero.
// RQ11: in port mode the external master reads and writes the data latch.
// RQ12: port mode makes the pins read strobe, write strobe, chip select.
// RQ13: software sets directions to input and pins digital before port mode.
// RQ14: a write starts when chip select and write strobe are both low.
// RQ15: a read starts when chip select and read strobe are both low.
// RQ16: read strobe low reads the data port only with chip selected.
// RQ17: write strobe low writes the data port only with chip selected.
// RQ18: chip select high makes the device ignore both strobes.
// RQ19: each finished external transfer sets the port flag, gated by enable, priority.
// RQ20: CPU read of data port clears input full; CPU write sets output full (the code sets it only in port mode).
//
// Added by the designer: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
module pscp_top
  import pscp_pkg::*;
(
  // system
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone classic slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // data port pins
  input wire logic [7:0] data_pin_i,
  output logic [7:0] data_pin_o,
  output logic [7:0] data_pin_oe_o,
  // control pins: read strobe, write strobe, chip select in port mode
  input wire logic [2:0] ctl_pin_i,
  output logic [2:0] ctl_pin_o,
  output logic [2:0] ctl_pin_oe_o,
  // gated port flag, split by priority
  output logic port_irq_high_o,
  output logic port_irq_low_o
);

  pscp_state_s state_reg;
  pscp_state_s state_next;
  pscp_pins_s pins_sync;
  logic access;
  logic wr_ok;
  logic ctl_digital;
  logic [2:0] ctl_level;
  logic rd_active;
  logic wr_active;

  // all pin inputs come from outside the clock domain
  pscp_sync #(
    .WIDTH(11)
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i({data_pin_i, ctl_pin_i}),
    .sync_o(pins_sync)
  );

  // both strobe checks need chip select low
  function automatic logic strobe_low(input logic [2:0] ctl, input int pin);
    strobe_low = !ctl[PSCP_CS_PIN] && !ctl[pin]; // RQ16 RQ17 RQ18
  endfunction

  // bus request accepted at the edge where ack is high
  assign access = cyc_i && stb_i && state_reg.ack;
  assign wr_ok = access && we_i && sel_i[0];
  assign ctl_digital = state_reg.analog_cfg[2:1] == PSCP_DIGITAL_CODE;
  // analog pins read zero
  assign ctl_level = ctl_digital ? pins_sync.ctl : PSCP_ZERO3; // RQ4
  assign rd_active = state_reg.mode && strobe_low(pins_sync.ctl, PSCP_RD_PIN); // RQ12
  assign wr_active = state_reg.mode && strobe_low(pins_sync.ctl, PSCP_WR_PIN); // RQ12

  // next state: bus side first, hardware events last so a hardware event beats a bus write
  always_comb begin
    state_next = state_reg;
    // ack one cycle after the request, dropped the cycle after
    state_next.ack = cyc_i && stb_i && !state_reg.ack;

    // read data is registered on the request cycle; unmapped reads zero
    if (!state_reg.ack) begin
      if (adr_i == PSCP_DATA_PORT_ADR) begin
        // port mode shows the byte the master wrote, else the pin levels
        state_next.rdata = state_reg.mode ? state_reg.in_latch : pins_sync.data; // RQ11
      end else if (adr_i == PSCP_DATA_LATCH_ADR) begin
        state_next.rdata = state_reg.data_latch;
      end else if (adr_i == PSCP_DATA_DIR_ADR) begin
        state_next.rdata = state_reg.data_dir;
      end else if (adr_i == PSCP_CTL_LEVEL_ADR) begin
        state_next.rdata = {5'h00, ctl_level}; // RQ4
      end else if (adr_i == PSCP_CTL_LATCH_ADR) begin
        state_next.rdata = {5'h00, state_reg.ctl_latch}; // RQ3
      end else if (adr_i == PSCP_CTL_STATUS_ADR) begin
        // bit 3 is unimplemented and reads zero
        state_next.rdata = {state_reg.input_buffer_full, state_reg.output_buffer_full, state_reg.input_overflow,
                            state_reg.mode, 1'b0, state_reg.ctl_dir}; // RQ7 RQ8 RQ10
      end else if (adr_i == PSCP_FLAG_ADR) begin
        state_next.rdata = {state_reg.irq_flag, 7'h00};
      end else if (adr_i == PSCP_ENABLE_ADR) begin
        state_next.rdata = {state_reg.irq_enable, 7'h00};
      end else if (adr_i == PSCP_PRIORITY_ADR) begin
        state_next.rdata = {state_reg.irq_priority, 7'h00};
      end else if (adr_i == PSCP_ANALOG_ADR) begin
        state_next.rdata = state_reg.analog_cfg;
      end else begin
        state_next.rdata = PSCP_ZERO8;
      end
    end

    // cpu read of the data port frees the input buffer
    if (access && !we_i && adr_i == PSCP_DATA_PORT_ADR) begin
      state_next.input_buffer_full = 1'b0; // RQ20
    end

    // register writes take effect at the acknowledging edge
    if (wr_ok) begin
      if (adr_i == PSCP_DATA_PORT_ADR) begin
        // writing the port writes the latch the master will read
        state_next.data_latch = dat_i[7:0];
        if (state_reg.mode) begin
          state_next.output_buffer_full = 1'b1; // RQ20
        end
      end else if (adr_i == PSCP_DATA_LATCH_ADR) begin
        state_next.data_latch = dat_i[7:0];
      end else if (adr_i == PSCP_DATA_DIR_ADR) begin
        state_next.data_dir = dat_i[7:0];
      end else if (adr_i == PSCP_CTL_LEVEL_ADR || adr_i == PSCP_CTL_LATCH_ADR) begin
        state_next.ctl_latch = dat_i[2:0]; // RQ3
      end else if (adr_i == PSCP_CTL_STATUS_ADR) begin
        // status bits 7 and 6 are read only; bit 5 can only be cleared
        state_next.input_overflow = state_reg.input_overflow && dat_i[PSCP_INPUT_OVERFLOW_BIT]; // RQ9
        state_next.mode = dat_i[PSCP_MODE_BIT]; // RQ10
        state_next.ctl_dir = dat_i[2:0]; // RQ1
      end else if (adr_i == PSCP_FLAG_ADR) begin
        state_next.irq_flag = dat_i[PSCP_IRQ_BIT];
      end else if (adr_i == PSCP_ENABLE_ADR) begin
        state_next.irq_enable = dat_i[PSCP_IRQ_BIT];
      end else if (adr_i == PSCP_PRIORITY_ADR) begin
        state_next.irq_priority = dat_i[PSCP_IRQ_BIT];
      end else if (adr_i == PSCP_ANALOG_ADR) begin
        state_next.analog_cfg = dat_i[7:0];
      end
    end

    // external transfer sequencer on synchronised strobes
    case (state_reg.phase)
      PSCP_IDLE: begin
        if (wr_active) begin
          state_next.phase = PSCP_EXT_WRITE; // RQ14
          state_next.data_sample = pins_sync.data;
        end else if (rd_active) begin
          state_next.phase = PSCP_EXT_READ; // RQ15
        end
      end
      PSCP_EXT_WRITE: begin
        if (wr_active) begin
          state_next.data_sample = pins_sync.data;
        end else begin
          // byte is the last one seen while the strobe was low
          state_next.in_latch = state_reg.data_sample; // RQ11
          state_next.input_overflow = state_next.input_overflow || state_reg.input_buffer_full; // RQ9
          state_next.input_buffer_full = 1'b1; // RQ7
          state_next.irq_flag = 1'b1; // RQ19
          state_next.phase = PSCP_IDLE;
        end
      end
      PSCP_EXT_READ: begin
        if (!rd_active) begin
          state_next.output_buffer_full = 1'b0; // RQ8
          state_next.irq_flag = 1'b1; // RQ19
          state_next.phase = PSCP_IDLE;
        end
      end
      default: begin
        state_next.phase = PSCP_IDLE;
      end
    endcase
  end

  // single register bank; pins come up analog because the config clears
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= '0;
      state_reg.data_dir <= PSCP_DATA_DIR_RST;
      state_reg.ctl_dir <= PSCP_CTL_DIR_RST; // RQ6
      state_reg.analog_cfg <= PSCP_ZERO8; // RQ6
      state_reg.phase <= PSCP_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // bus outputs
  assign ack_o = state_reg.ack;
  assign dat_o = {PSCP_PAD24, state_reg.rdata};

  // data pins: driven by the master's read in port mode, else by direction bits;
  // strobes pass the synchroniser, so the bus appears about three cycles late
  assign data_pin_o = state_reg.data_latch;
  assign data_pin_oe_o = state_reg.mode ?
                         {8{state_reg.phase == PSCP_EXT_READ}} : ~state_reg.data_dir; // RQ11

  // control pins obey direction even when analog; software keeps them inputs
  assign ctl_pin_o = state_reg.ctl_latch; // RQ2
  assign ctl_pin_oe_o = ~state_reg.ctl_dir; // RQ2 RQ5 RQ13

  // flag gated by enable, routed by priority
  assign port_irq_high_o = state_reg.irq_flag && state_reg.irq_enable &&
                           state_reg.irq_priority; // RQ19
  assign port_irq_low_o = state_reg.irq_flag && state_reg.irq_enable &&
                          !state_reg.irq_priority; // RQ19

endmodule
`default_nettype wire

//--- pscp_checker.sv
`timescale 1ns/1ps
`default_nettype none
// watches the bus handshake and pin enables at the top ports
module pscp_checker
  import pscp_pkg::*;
(
  // system
  input wire logic clk_i,
  input wire logic rst_i,
  // bus
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  // pins
  input wire logic [2:0] ctl_pin_i,
  input wire logic [7:0] data_pin_oe_o,
  input wire logic [2:0] ctl_pin_oe_o,
  input wire logic port_irq_high_o,
  input wire logic port_irq_low_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // read strobe with chip selected, seen as one level
  logic rd_sel;
  assign rd_sel = !ctl_pin_i[0] && !ctl_pin_i[2];
  a_ack_next: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("ack missing after request");
  a_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  a_ack_cause: assert property (!(cyc_i && stb_i) |=> !ack_o)
    else $error("ack without request");
  a_upper_zero: assert property (ack_o |-> dat_o[31:8] == 24'h000000)
    else $error("upper read lanes not zero");
  a_dir_drive: assert property (cyc_i && stb_i && we_i && ack_o && sel_i[0]
    && adr_i == PSCP_CTL_STATUS_ADR |=> ctl_pin_oe_o == ~$past(dat_i[2:0]))
    else $error("control enable not from direction");
  a_reset_float: assert property ($fell(rst_i) |->
    ctl_pin_oe_o == PSCP_ZERO3 && data_pin_oe_o == PSCP_ZERO8)
    else $error("pins driven after reset");
  a_irq_split: assert property (!(port_irq_high_o && port_irq_low_o))
    else $error("both priority outputs high");
  // data drive only by a register write or a selected read strobe
  a_oe_cause: assert property ($rose(|data_pin_oe_o) |-> $past(ack_o)
    || $past(rd_sel, 2) || $past(rd_sel, 3) || $past(rd_sel, 4))
    else $error("data drive without cause");
endmodule
bind pscp_top pscp_checker u_chk (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i,
  .sel_i, .dat_i, .dat_o, .ack_o, .ctl_pin_i, .data_pin_oe_o, .ctl_pin_oe_o,
  .port_irq_high_o, .port_irq_low_o);
`default_nettype wire

//--- pscp_ext_master.sv
`timescale 1ns/1ps
`default_nettype none
// external byte-wide master on the data and control pins
module pscp_ext_master (
  // clock
  input wire logic clk_i,
  // wire level of the data pins
  input wire logic [7:0] bus_i,
  // strobes {select, write, read}, low active, and data
  output logic [2:0] ctl_o,
  output logic [7:0] dat_o
);
  logic drv = 1'b0;
  logic [7:0] val = 8'h00;
  logic [7:0] junk = 8'h3c;
  logic [7:0] got;
  initial ctl_o = 3'h7;
  // released bus toggles so no stale byte can pass for data
  always @(posedge clk_i) junk <= ~junk;
  assign dat_o = drv ? val : junk;
  // strobes low 5 cycles, high at least 6 before the next
  task xfer(input logic [2:0] c, input logic [7:0] b);
    @(posedge clk_i);
    ctl_o <= c;
    val <= b;
    drv <= !c[1];
    repeat (5) @(posedge clk_i);
    got = bus_i;
    ctl_o <= 3'h7;
    repeat (5) @(posedge clk_i);
    drv <= 1'b0;
  endtask
endmodule
`default_nettype wire

//--- pscp_test.sv
`timescale 1ns/1ps
`default_nettype none
// bench: bus tasks, external master, reference flag model
module pscp_test
  import pscp_pkg::*;
;
  logic clk_i, ack_o, irq_hi, irq_lo;
  logic rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic [7:0] adr_i = 8'h00, data_pin_i, data_pin_o, data_pin_oe_o, m_dat;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0, dat_o, rdv, b, seed = 32'd92804;
  logic [2:0] ctl_pin_i, ctl_pin_o, ctl_pin_oe_o, m_ctl;
  logic [7:0] ra[8] = '{8'h08, 8'h14, 8'h0c, 8'h18, 8'h1c, 8'h20, 8'h24, 8'h30};
  logic [7:0] rv[8] = '{8'hff, 8'h07, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  int miscompares = 0, checks_done = 0, cycles = 0, input_buffer_full = 0, output_buffer_full = 0, input_overflow = 0;
  logic [7:0] in_q[$];
  // wire levels: whoever enables a bit drives it
  assign data_pin_i = (data_pin_oe_o & data_pin_o) | (~data_pin_oe_o & m_dat);
  assign ctl_pin_i = (ctl_pin_oe_o & ctl_pin_o) | (~ctl_pin_oe_o & m_ctl);
  pscp_top u_dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
    .dat_o, .ack_o, .data_pin_i, .data_pin_o, .data_pin_oe_o, .ctl_pin_i, .ctl_pin_o,
    .ctl_pin_oe_o, .port_irq_high_o(irq_hi), .port_irq_low_o(irq_lo));
  pscp_ext_master u_ext (.clk_i, .bus_i(data_pin_i), .ctl_o(m_ctl), .dat_o(m_dat));
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  // hang guard, far beyond the roughly 180 cycles needed
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      complete_run;
    end
  end
  function logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // expected status byte with port mode and inputs set
  function logic [31:0] st();
    return 32'(input_buffer_full * 128 + output_buffer_full * 64 + input_overflow * 32 + 23);
  endfunction
  task complete_run;
    if (miscompares == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] s);
    checks_done++;
    if (s !== e) begin
      $display("Error %s expected %h seen %h", n, e, s);
      miscompares++;
    end
  endtask
  // iff sees the pre-edge ack, so no race with the design
  task wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    sel_i <= 4'h1;
    dat_i <= {24'h0, d};
    @(posedge clk_i iff ack_o === 1'b1);
    rdv = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask
  task rdc(input string n, input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 8'h00);
    chk(n, e, rdv);
  endtask
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 8; i++) rdc("reset value", ra[i], {24'h0, rv[i]});
    b = xs();
    wb(1'b1, 8'h24, 8'h07);
    wb(1'b1, 8'h10, b[7:0]);
    rdc("pin level", 8'h0c, 32'h7);
    rdc("ctl latch", 8'h10, {29'h0, b[2:0]});
    wb(1'b1, 8'h14, 8'h00);
    @(posedge clk_i);
    chk("ctl drive", {26'h0, 3'h7, b[2:0]}, {26'h0, ctl_pin_oe_o, ctl_pin_o});
    wb(1'b1, 8'h24, 8'h00);
    rdc("analog level", 8'h0c, 32'h0);
    chk("analog drive", 32'h7, {29'h0, ctl_pin_oe_o});
    wb(1'b1, 8'h14, 8'h07);
    wb(1'b1, 8'h24, 8'h07);
    wb(1'b1, 8'h1c, 8'h80);
    wb(1'b1, 8'h20, 8'h80);
    // bit 3 written as one must still read back as zero
    wb(1'b1, 8'h14, 8'h1f);
    // second write lands over an unread byte
    repeat (2) begin
      b = xs();
      u_ext.xfer(3'h1, b[7:0]);
      input_overflow = input_buffer_full;
      input_buffer_full = 1;
      in_q.push_back(b[7:0]);
      rdc("status", 8'h14, st());
    end
    chk("irq pair", 32'h2, {30'h0, irq_hi, irq_lo});
    rdc("flag", 8'h18, 32'h80);
    rdc("data port", 8'h00, {24'h0, in_q[$]});
    input_buffer_full = 0;
    rdc("status", 8'h14, st());
    wb(1'b1, 8'h14, 8'h17);
    input_overflow = 0;
    rdc("status", 8'h14, st());
    b = xs();
    wb(1'b1, 8'h00, b[7:0]);
    output_buffer_full = 1;
    rdc("status", 8'h14, st());
    u_ext.xfer(3'h2, 8'h00);
    output_buffer_full = 0;
    chk("ext read", {24'h0, b[7:0]}, {24'h0, u_ext.got});
    rdc("status", 8'h14, st());
    wb(1'b1, 8'h18, 8'h00);
    u_ext.xfer(3'h5, 8'ha5);
    rdc("status", 8'h14, st());
    // read strobe without chip select must leave the output byte pending
    wb(1'b1, 8'h00, 8'h5a);
    output_buffer_full = 1;
    u_ext.xfer(3'h6, 8'h00);
    rdc("status", 8'h14, st());
    rdc("flag", 8'h18, 32'h0);
    wb(1'b1, 8'h20, 8'h00);
    u_ext.xfer(3'h1, 8'h3c);
    chk("irq pair", 32'h1, {30'h0, irq_hi, irq_lo});
    complete_run;
  end
endmodule
`default_nettype wire
